// *** pkg/lom_pkg.sv ***
package lom_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [6:0] LOM_OFS_LDAC_TO_LEFT = 7'h52;
	localparam logic [6:0] LOM_OFS_SECOND_RIGHT_LINE_INPUT_TO_LEFT = 7'h53;
	localparam logic [6:0] LOM_OFS_RAMP_TO_LEFT = 7'h54;
	localparam logic [6:0] LOM_OFS_RDAC_TO_LEFT = 7'h55;
	localparam logic [6:0] LOM_OFS_LEFT_LEVEL = 7'h56;
	localparam logic [6:0] LOM_OFS_SECOND_LEFT_LINE_INPUT_TO_RIGHT = 7'h57;
	localparam logic [6:0] LOM_OFS_LAMP_TO_RIGHT = 7'h58;
	localparam logic [6:0] LOM_OFS_LDAC_TO_RIGHT = 7'h59;

	////////////////////////////////////////////////////////////////////////
	// widths
	localparam int LOM_ADDR_W = 7;
	localparam int LOM_DATA_W = 8;
	localparam int LOM_VOL_W = 7;
	localparam int LOM_LEVEL_W = 4;
	localparam int LOM_NUM_PATHS = 7;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int LOM_ROUTE_EN_BIT = 7;
	localparam int LOM_VOL_LSB = 0;
	localparam int LOM_LEVEL_LSB = 4;
	localparam int LOM_UNMUTE_BIT = 3;
	localparam int LOM_RSVD_BIT = 2;
	localparam int LOM_PENDING_BIT = 1;
	localparam int LOM_POWERED_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic LOM_ROUTE_EN_RST = 1'h0;
	localparam logic [6:0] LOM_VOL_RST = 7'h00;
	localparam logic [3:0] LOM_LEVEL_RST = 4'h0;
	localparam logic LOM_UNMUTE_RST = 1'h0;
	localparam logic LOM_RSVD_VAL = 1'h0;
	localparam logic LOM_PENDING_RST = 1'h1;
	localparam logic LOM_POWERED_RST = 1'h0;
	localparam logic [7:0] LOM_UNMAPPED_RD = 8'h00;

	// highest level code that is defined, 9 dB
	localparam logic [3:0] LOM_LEVEL_MAX = 4'h9;

endpackage : lom_pkg

// *** core/lom_regs.sv ***
`timescale 1ns/10ps
// Functional notes
// - bit 7 of the left-dac-path-to-left-line-output register routes that path to the left line output when 1.
// - bit 7 of the second-right-line-input-to-left register connects that input to the left line output when 1.
// - bit 7 of the right-input-amplifier-to-left register routes that amplifier to the left line output when 1.
// - bit 7 of the right-dac-path-to-left register enables that path when 1 and disables it when 0.
// - bit 7 of the second-left-line-input-to-right register connects that input to the right line output when 1.
// - bit 7 of the left-input-amplifier-to-right register routes that amplifier to the right line output when 1.
// - bit 7 of the left-dac-path-to-right register enables that path to the right line output when 1.
// - bits 6..0 of each routing register are a read/write volume code, zero at reset, driven to the gain stage.
// - bits 7..4 of the left level register are a read/write level code, zero at reset, 1 dB per step up to 9 dB.
// - bit 3 of the left level register mutes the output when 0 (reset) and unmutes it when 1.
// - bit 2 of the left level register is reserved, reads 0, and software does not write it.
// - bit 1 of the left level register is read-only, 1 while a programmed gain is still pending, 0 once applied.
// - bit 0 of the left level register is read-only, 0 until the driver is fully powered, then 1.

module lom_regs
	import lom_pkg::*;
#(
	parameter int NUM_PATHS = LOM_NUM_PATHS
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic [LOM_ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_en_in,
	input wire logic [LOM_DATA_W-1:0] reg_wr_data_in,
	input wire logic reg_rd_en_in,
	output logic [LOM_DATA_W-1:0] reg_rd_data_out,
	output logic reg_rd_valid_out,
	output logic reg_addr_hit_out,
	input wire logic left_gain_pending_in,
	input wire logic left_powered_in,
	output logic left_dac_path_to_left_en_out,
	output logic [LOM_VOL_W-1:0] left_dac_path_to_left_vol_out,
	output logic second_right_line_input_to_left_en_out,
	output logic [LOM_VOL_W-1:0] second_right_line_input_to_left_vol_out,
	output logic right_input_amplifier_to_left_en_out,
	output logic [LOM_VOL_W-1:0] right_input_amplifier_to_left_vol_out,
	output logic right_dac_path_to_left_en_out,
	output logic [LOM_VOL_W-1:0] right_dac_path_to_left_vol_out,
	output logic second_left_line_input_to_right_en_out,
	output logic [LOM_VOL_W-1:0] second_left_line_input_to_right_vol_out,
	output logic left_input_amplifier_to_right_en_out,
	output logic [LOM_VOL_W-1:0] left_input_amplifier_to_right_vol_out,
	output logic left_dac_path_to_right_en_out,
	output logic [LOM_VOL_W-1:0] left_dac_path_to_right_vol_out,
	output logic [LOM_LEVEL_W-1:0] left_line_output_level_out,
	output logic left_line_output_unmute_out,
	output logic left_line_output_level_valid_out
);

	////////////////////////////////////////////////////////////////////////
	// address decode

	// path index order: left-side paths first, then right-side paths
	logic [NUM_PATHS-1:0] path_sel;
	logic level_sel;
	logic any_sel;

	always_comb begin
		path_sel = '0;
		level_sel = 1'b0;
		if (reg_addr_in == LOM_OFS_LDAC_TO_LEFT) begin
			path_sel[0] = 1'b1;
		end else if (reg_addr_in == LOM_OFS_SECOND_RIGHT_LINE_INPUT_TO_LEFT) begin
			path_sel[1] = 1'b1;
		end else if (reg_addr_in == LOM_OFS_RAMP_TO_LEFT) begin
			path_sel[2] = 1'b1;
		end else if (reg_addr_in == LOM_OFS_RDAC_TO_LEFT) begin
			path_sel[3] = 1'b1;
		end else if (reg_addr_in == LOM_OFS_LEFT_LEVEL) begin
			level_sel = 1'b1;
		end else if (reg_addr_in == LOM_OFS_SECOND_LEFT_LINE_INPUT_TO_RIGHT) begin
			path_sel[4] = 1'b1;
		end else if (reg_addr_in == LOM_OFS_LAMP_TO_RIGHT) begin
			path_sel[5] = 1'b1;
		end else if (reg_addr_in == LOM_OFS_LDAC_TO_RIGHT) begin
			path_sel[6] = 1'b1;
		end
	end

	assign any_sel = (|path_sel) | level_sel;
	assign reg_addr_hit_out = any_sel;

	////////////////////////////////////////////////////////////////////////
	// routing registers, one per source path

	// one element per path, so each generate process drives its own variable
	logic route_en [NUM_PATHS];
	logic [LOM_VOL_W-1:0] route_vol [NUM_PATHS];

	for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				route_en[p] <= LOM_ROUTE_EN_RST;
				route_vol[p] <= LOM_VOL_RST;
			end else if (ce_in && reg_wr_en_in && path_sel[p]) begin
				route_en[p] <= reg_wr_data_in[LOM_ROUTE_EN_BIT];
				route_vol[p] <= reg_wr_data_in[LOM_VOL_LSB +: LOM_VOL_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// left line output level control

	logic [LOM_LEVEL_W-1:0] left_level;
	logic left_unmute;

	// the code is stored as written; reserved codes are the writer's to avoid, so no clamping here
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			left_level <= LOM_LEVEL_RST;
			left_unmute <= LOM_UNMUTE_RST;
		end else if (ce_in && reg_wr_en_in && level_sel) begin
			left_level <= reg_wr_data_in[LOM_LEVEL_LSB +: LOM_LEVEL_W];
			left_unmute <= reg_wr_data_in[LOM_UNMUTE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status sampled from the analog stage

	// a register stage keeps read data stable against a slow analog edge
	logic left_pending;
	logic left_powered;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			left_pending <= LOM_PENDING_RST;
			left_powered <= LOM_POWERED_RST;
		end else if (ce_in) begin
			left_pending <= left_gain_pending_in;
			left_powered <= left_powered_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	logic [LOM_DATA_W-1:0] next_rd_data;
	logic [LOM_DATA_W-1:0] level_word;

	always_comb begin
		level_word = '0;
		level_word[LOM_LEVEL_LSB +: LOM_LEVEL_W] = left_level;
		level_word[LOM_UNMUTE_BIT] = left_unmute;
		level_word[LOM_RSVD_BIT] = LOM_RSVD_VAL;
		level_word[LOM_PENDING_BIT] = left_pending;
		level_word[LOM_POWERED_BIT] = left_powered;
	end

	always_comb begin
		next_rd_data = LOM_UNMAPPED_RD;
		if (level_sel) begin
			next_rd_data = level_word;
		end else begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				if (path_sel[p]) begin
					next_rd_data = {route_en[p], route_vol[p]};
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rd_data_out <= LOM_UNMAPPED_RD;
		end else if (ce_in && reg_rd_en_in) begin
			reg_rd_data_out <= next_rd_data;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rd_valid_out <= 1'b0;
		end else if (ce_in) begin
			reg_rd_valid_out <= reg_rd_en_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// analog-side outputs, straight from the registers except the level-valid flag, which compares the level code

	assign left_dac_path_to_left_en_out = route_en[0];
	assign left_dac_path_to_left_vol_out = route_vol[0];
	assign second_right_line_input_to_left_en_out = route_en[1];
	assign second_right_line_input_to_left_vol_out = route_vol[1];
	assign right_input_amplifier_to_left_en_out = route_en[2];
	assign right_input_amplifier_to_left_vol_out = route_vol[2];
	assign right_dac_path_to_left_en_out = route_en[3];
	assign right_dac_path_to_left_vol_out = route_vol[3];
	assign second_left_line_input_to_right_en_out = route_en[4];
	assign second_left_line_input_to_right_vol_out = route_vol[4];
	assign left_input_amplifier_to_right_en_out = route_en[5];
	assign left_input_amplifier_to_right_vol_out = route_vol[5];
	assign left_dac_path_to_right_en_out = route_en[6];
	assign left_dac_path_to_right_vol_out = route_vol[6];
	assign left_line_output_level_out = left_level;
	assign left_line_output_unmute_out = left_unmute;
	// flags a reserved code so the analog side can hold its last good gain
	assign left_line_output_level_valid_out = (left_level <= LOM_LEVEL_MAX);

endmodule : lom_regs

// *** verif/lom_regs_props.sv ***
`timescale 1ns/10ps
module lom_regs_props
	import lom_pkg::*;
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic [LOM_ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_en_in,
	input wire logic [LOM_DATA_W-1:0] reg_wr_data_in,
	input wire logic reg_rd_en_in,
	input wire logic [LOM_DATA_W-1:0] reg_rd_data_out,
	input wire logic reg_rd_valid_out,
	input wire logic reg_addr_hit_out,
	input wire logic left_gain_pending_in,
	input wire logic left_powered_in,
	input wire logic left_dac_path_to_left_en_out,
	input wire logic [LOM_VOL_W-1:0] left_dac_path_to_left_vol_out,
	input wire logic right_dac_path_to_left_en_out,
	input wire logic left_dac_path_to_right_en_out,
	input wire logic [LOM_LEVEL_W-1:0] left_line_output_level_out,
	input wire logic left_line_output_unmute_out,
	input wire logic left_line_output_level_valid_out
);
	wire logic wr = ce_in && reg_wr_en_in;
	wire logic rd = ce_in && reg_rd_en_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	////////////////////////////////////////////////////////////////////////
	a_ldac_left_en: assert property (wr && reg_addr_in == LOM_OFS_LDAC_TO_LEFT |=>
		left_dac_path_to_left_en_out == $past(reg_wr_data_in[7])) else $error("enable at 0x52 wrong");
	a_rdac_left_en: assert property (wr && reg_addr_in == LOM_OFS_RDAC_TO_LEFT |=>
		right_dac_path_to_left_en_out == $past(reg_wr_data_in[7])) else $error("enable at 0x55 wrong");
	a_ldac_right_en: assert property (wr && reg_addr_in == LOM_OFS_LDAC_TO_RIGHT |=>
		left_dac_path_to_right_en_out == $past(reg_wr_data_in[7])) else $error("enable at 0x59 wrong");
	a_ldac_left_vol: assert property (wr && reg_addr_in == LOM_OFS_LDAC_TO_LEFT |=>
		left_dac_path_to_left_vol_out == $past(reg_wr_data_in[6:0])) else $error("volume at 0x52 wrong");
	a_level_write: assert property (wr && reg_addr_in == LOM_OFS_LEFT_LEVEL |=>
		left_line_output_level_out == $past(reg_wr_data_in[7:4])) else $error("level code wrong");
	a_unmute_write: assert property (wr && reg_addr_in == LOM_OFS_LEFT_LEVEL |=>
		left_line_output_unmute_out == $past(reg_wr_data_in[3])) else $error("mute bit wrong");
	a_level_valid: assert property (left_line_output_level_valid_out ==
		(left_line_output_level_out <= LOM_LEVEL_MAX)) else $error("level valid flag wrong");
	// status flops lag the inputs by one enabled edge, hence depth 2
	a_status_read: assert property (rd && reg_addr_in == LOM_OFS_LEFT_LEVEL && $past(ce_in) && $past(arst_n_in) |=>
		reg_rd_data_out[2:0] == {1'b0, $past(left_gain_pending_in, 2), $past(left_powered_in, 2)})
		else $error("status bits wrong");
	a_unmapped_read: assert property (rd && !reg_addr_hit_out |=> reg_rd_data_out == LOM_UNMAPPED_RD)
		else $error("unmapped read not zero");
	a_rd_valid_pulse: assert property (ce_in |=> reg_rd_valid_out == $past(reg_rd_en_in))
		else $error("read valid wrong");
endmodule : lom_regs_props

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
module tb_top import lom_pkg::*;;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic pend = 1'b1;
	logic pow = 1'b0;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] d;
	logic [6:0] a;
	logic rvalid, hit, lvl_ok, unmute;
	logic [3:0] level;
	logic en [7];
	logic [6:0] vol [7];
	int n_errors = 0;
	int total_checks = 0;
	always #20 clk_in = ~clk_in;
	lom_regs dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .reg_addr_in(addr),
		.reg_wr_en_in(wr_en), .reg_wr_data_in(wdata), .reg_rd_en_in(rd_en), .reg_rd_data_out(rdata),
		.reg_rd_valid_out(rvalid), .reg_addr_hit_out(hit), .left_gain_pending_in(pend), .left_powered_in(pow),
		.left_dac_path_to_left_en_out(en[0]), .left_dac_path_to_left_vol_out(vol[0]),
		.second_right_line_input_to_left_en_out(en[1]), .second_right_line_input_to_left_vol_out(vol[1]),
		.right_input_amplifier_to_left_en_out(en[2]), .right_input_amplifier_to_left_vol_out(vol[2]),
		.right_dac_path_to_left_en_out(en[3]), .right_dac_path_to_left_vol_out(vol[3]),
		.second_left_line_input_to_right_en_out(en[4]), .second_left_line_input_to_right_vol_out(vol[4]),
		.left_input_amplifier_to_right_en_out(en[5]), .left_input_amplifier_to_right_vol_out(vol[5]),
		.left_dac_path_to_right_en_out(en[6]), .left_dac_path_to_right_vol_out(vol[6]),
		.left_line_output_level_out(level), .left_line_output_unmute_out(unmute),
		.left_line_output_level_valid_out(lvl_ok));
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [6:0] wa, input logic [7:0] wd);
		@(negedge clk_in);
		addr = wa;
		wdata = wd;
		wr_en = 1'b1;
		@(negedge clk_in);
		wr_en = 1'b0;
	endtask : wr
	task rd(input logic [6:0] ra, input logic [7:0] exp);
		@(negedge clk_in);
		addr = ra;
		rd_en = 1'b1;
		@(negedge clk_in);
		rd_en = 1'b0;
		chk({7'h00, rvalid}, 8'h01);
		chk(rdata, exp);
	endtask : rd
	task test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////
	// all waits are fixed cycle counts, so this only guards a stuck clock
	initial begin
		#1000000;
		n_errors++;
		test_done;
	end
	initial begin
		repeat (5) @(negedge clk_in);
		arst_n_in = 1'b1;
		for (int i = 0; i < 8; i++) rd(7'h52 + 7'(i), i == 4 ? 8'h02 : 8'h00);
		// en high then low per path, so a stuck enable shows either way
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 7; i++) begin
				a = i < 4 ? 7'h52 + 7'(i) : 7'h53 + 7'(i);
				d = p == 0 ? {1'b1, 7'(i * 17 + 3)} : 8'h7f;
				wr(a, d);
				chk({en[i], vol[i]}, d);
				rd(a, d);
			end
		end
		pend = 1'b0;
		pow = 1'b1;
		wr(7'h56, 8'h9f);
		chk({level, unmute, lvl_ok, 2'b00}, 8'h9c);
		rd(7'h56, 8'h99);
		wr(7'h56, 8'h00);
		chk({level, unmute, lvl_ok, 2'b00}, 8'h04);
		pend = 1'b1;
		pow = 1'b0;
		rd(7'h56, 8'h02);
		ce_in = 1'b0;
		wr(7'h52, 8'hff);
		ce_in = 1'b1;
		chk({en[0], vol[0]}, 8'h7f);
		wr(7'h5a, 8'hff);
		rd(7'h5a, 8'h00);
		chk({7'h00, hit}, 8'h00);
		rd(7'h51, 8'h00);
		rd(7'h52, 8'h7f);
		chk({7'h00, hit}, 8'h01);
		test_done;
	end
endmodule : tb_top
bind lom_regs lom_regs_props chk_u (.*);
